// file: pesc_regs.svh
`ifndef PESC_REGS_SVH
`define PESC_REGS_SVH
// Register indices on the management port.
`define PESC_ADDR_FALSE_CARRIER  5'h13
`define PESC_ADDR_TX_SEED        5'h14
`define PESC_ADDR_RX_ERR         5'h15
`define PESC_ADDR_RX_SEED        5'h16
`define PESC_ADDR_IRQ_STATUS     5'h1a
`define PESC_ADDR_IRQ_MASK       5'h1b
// Field positions and widths.
`define PESC_LOAD_BIT            15
`define PESC_SEED_W              11
`define PESC_CNT_W               16
`define PESC_CNT_MAX             16'hffff
`define PESC_SEED_ZERO           11'h000
// Interrupt status bit positions.
`define PESC_IRQ_FC              0
`define PESC_IRQ_RXERR           1
`define PESC_IRQ_FC_SAT          2
`define PESC_IRQ_RXERR_WRAP      3
`define PESC_IRQ_W               4
`endif

// file: pesc_pkg.sv
package pesc_pkg;
   // Counter update behaviour at the top of the range.
   typedef enum logic {PESC_SATURATE, PESC_WRAP} pesc_ovf_t;
   typedef logic [15:0] pesc_word_t;
endpackage

// file: pesc_event_end.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Synchronises an event level and pulses when it ends.
// ************************************************************
module pesc_event_end
(
   input  wire logic i_clk_sys,   // System clock.
   input  wire logic i_reset_n,   // Asynchronous reset, active low.
   input  wire logic i_level,     // Event level from outside the domain.
   output logic      o_end_pulse  // One pulse on the falling edge.
);
   logic meta_reg;
   logic sync_reg;
   logic prev_reg;

   // Two-stage synchroniser and an edge history stage.
   always_ff @(posedge i_clk_sys or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         prev_reg <= 1'b0;
      end
      else
      begin
         meta_reg <= i_level;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   // A long event gives one pulse only, at its end.
   assign o_end_pulse = prev_reg & ~sync_reg;
endmodule
`default_nettype wire

// file: pesc_counter.sv
`include "pesc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Sixteen-bit statistics counter, cleared when read.
// ************************************************************
module pesc_counter
   import pesc_pkg::*;
#(
   parameter pesc_ovf_t MODE = PESC_SATURATE
)
(
   input  wire logic       i_clk_sys,  // System clock.
   input  wire logic       i_reset_n,  // Asynchronous reset, active low.
   input  wire logic       i_inc,      // Count one event.
   input  wire logic       i_rd_clr,   // Read clears the count.
   output pesc_word_t      o_count,    // Current count.
   output logic            o_top       // Pulse when at maximum on increment.
);
   pesc_word_t count_next;

   // A clear with a simultaneous event leaves a count of one.
   always_comb
   begin
      count_next = o_count;
      if (i_rd_clr)
         count_next = 16'h0000;
      if (i_inc)
      begin
         if (i_rd_clr)
            count_next = 16'h0001;
         else if (o_count != `PESC_CNT_MAX)
            count_next = o_count + 16'h0001;
         else if (MODE == PESC_WRAP)
            count_next = 16'h0000;
      end
   end

   assign o_top = i_inc & ~i_rd_clr & (o_count == `PESC_CNT_MAX);

   // Count register, zero after reset.
   always_ff @(posedge i_clk_sys or negedge i_reset_n)
   begin
      if (!i_reset_n)
         o_count <= 16'h0000;
      else
         o_count <= count_next;
   end
endmodule
`default_nettype wire

// file: pesc_top.sv
// Decided for this implementation: the strobed register port.
`include "pesc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module pesc_top
   import pesc_pkg::*;
(
   input  wire logic        i_clk_sys,       // System clock, 10 MHz.
   input  wire logic        i_reset_n,       // Asynchronous reset, active low.
   input  wire logic [4:0]  i_addr,          // Register index.
   input  wire logic [15:0] i_wdata,         // Write data.
   input  wire logic        i_wr,            // Write strobe.
   input  wire logic        i_rd,            // Read strobe.
   output logic      [15:0] o_rdata,         // Read data, one cycle later.
   input  wire logic        i_false_carrier, // False-carrier event level.
   input  wire logic        i_rx_err_pkt,    // Errored packet level, ends at packet end.
   input  wire logic        i_compat_mode,   // Legacy compatibility mode level.
   input  wire logic        i_tx_load_done,  // Scrambler has taken the seed.
   input  wire logic        i_rx_load_done,  // Descrambler has taken the seed.
   output logic      [10:0] o_tx_seed,       // Seed to the transmit scrambler.
   output logic             o_tx_load,       // Scrambler load request level.
   output logic             o_tx_bypass,     // Transmit scrambling bypassed.
   output logic      [10:0] o_rx_seed,       // Seed to the receive descrambler.
   output logic             o_rx_load,       // Descrambler load request level.
   output logic             o_rx_bypass,     // Receive descrambling bypassed.
   output logic             o_irq            // Interrupt, active high level.
);
   // ************************************************************
   // Input synchronisers and event detection.
   // ************************************************************
   // Event end pulses and synchronised level inputs.
   logic fc_end;
   logic rxe_end;
   logic compat_meta_reg;
   logic compat_reg;
   logic tx_done_meta_reg;
   logic tx_done_reg;
   logic rx_done_meta_reg;
   logic rx_done_reg;

   // False carrier counted once at its end.
   pesc_event_end u_fc_end
   (
      .i_clk_sys   (i_clk_sys),
      .i_reset_n   (i_reset_n),
      .i_level     (i_false_carrier),
      .o_end_pulse (fc_end)
   );

   // An errored packet counted once when its error flag drops.
   pesc_event_end u_rxe_end
   (
      .i_clk_sys   (i_clk_sys),
      .i_reset_n   (i_reset_n),
      .i_level     (i_rx_err_pkt),
      .o_end_pulse (rxe_end)
   );

   // Compatibility mode passes two flip-flops before any logic reads it.
   always_ff @(posedge i_clk_sys or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         compat_meta_reg <= 1'b0;
         compat_reg      <= 1'b0;
      end
      else
      begin
         compat_meta_reg <= i_compat_mode;
         compat_reg      <= compat_meta_reg;
      end
   end

   // Scrambler handshake level, synchronised the same way.
   always_ff @(posedge i_clk_sys or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         tx_done_meta_reg <= 1'b0;
         tx_done_reg      <= 1'b0;
      end
      else
      begin
         tx_done_meta_reg <= i_tx_load_done;
         tx_done_reg      <= tx_done_meta_reg;
      end
   end

   // Descrambler handshake level, synchronised the same way.
   always_ff @(posedge i_clk_sys or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         rx_done_meta_reg <= 1'b0;
         rx_done_reg      <= 1'b0;
      end
      else
      begin
         rx_done_meta_reg <= i_rx_load_done;
         rx_done_reg      <= rx_done_meta_reg;
      end
   end

   // ************************************************************
   // Register access decode.
   // ************************************************************
   // Compares a register index with one decoded address.
   function automatic logic hit(input logic [4:0] a, input logic [4:0] idx);
      hit = (a == idx);
   endfunction

   logic rd_fc;
   logic rd_rxe;
   logic wr_tx;
   logic wr_rx;
   logic wr_ist;
   logic wr_imask;

   // Each access is one strobe qualified by one register index.
   assign rd_fc    = i_rd & hit(i_addr, `PESC_ADDR_FALSE_CARRIER);
   assign rd_rxe   = i_rd & hit(i_addr, `PESC_ADDR_RX_ERR);
   assign wr_tx    = i_wr & hit(i_addr, `PESC_ADDR_TX_SEED);
   assign wr_rx    = i_wr & hit(i_addr, `PESC_ADDR_RX_SEED);
   assign wr_ist   = i_wr & hit(i_addr, `PESC_ADDR_IRQ_STATUS);
   assign wr_imask = i_wr & hit(i_addr, `PESC_ADDR_IRQ_MASK);

   // ************************************************************
   // Statistics counters.
   // ************************************************************
   // Current counts, read back through the data multiplexer.
   pesc_word_t fc_count;
   pesc_word_t rxe_count;
   logic       fc_top;
   logic       rxe_top;

   // False-carrier count saturates and clears on read.
   pesc_counter #(.MODE(PESC_SATURATE)) u_fc_cnt
   (
      .i_clk_sys (i_clk_sys),
      .i_reset_n (i_reset_n),
      .i_inc     (fc_end),
      .i_rd_clr  (rd_fc),
      .o_count   (fc_count),
      .o_top     (fc_top)
   );

   // Receive-error count wraps and clears on read.
   pesc_counter #(.MODE(PESC_WRAP)) u_rxe_cnt
   (
      .i_clk_sys (i_clk_sys),
      .i_reset_n (i_reset_n),
      .i_inc     (rxe_end),
      .i_rd_clr  (rd_rxe),
      .o_count   (rxe_count),
      .o_top     (rxe_top)
   );

   // ************************************************************
   // Scrambler and descrambler seed registers.
   // ************************************************************
   // Seed writes are dropped in compatibility mode.
   always_ff @(posedge i_clk_sys or negedge i_reset_n)
   begin
      if (!i_reset_n)
         o_tx_seed <= `PESC_SEED_ZERO;
      else if (compat_reg)
         o_tx_seed <= o_tx_seed;
      else if (wr_tx)
         o_tx_seed <= i_wdata[`PESC_SEED_W-1:0];
   end

   // Descrambler seed follows the same policy as the scrambler seed.
   always_ff @(posedge i_clk_sys or negedge i_reset_n)
   begin
      if (!i_reset_n)
         o_rx_seed <= `PESC_SEED_ZERO;
      else if (compat_reg)
         o_rx_seed <= o_rx_seed;
      else if (wr_rx)
         o_rx_seed <= i_wdata[`PESC_SEED_W-1:0];
   end

   // Load bits are set by software and cleared when the copy is done.
   always_ff @(posedge i_clk_sys or negedge i_reset_n)
   begin
      if (!i_reset_n)
         o_tx_load <= 1'b0;
      else if (wr_tx && i_wdata[`PESC_LOAD_BIT] && !compat_reg)
         o_tx_load <= 1'b1;
      else if (tx_done_reg || compat_reg)
         o_tx_load <= 1'b0;
   end

   // Descrambler load bit follows the same policy as the scrambler one.
   always_ff @(posedge i_clk_sys or negedge i_reset_n)
   begin
      if (!i_reset_n)
         o_rx_load <= 1'b0;
      else if (wr_rx && i_wdata[`PESC_LOAD_BIT] && !compat_reg)
         o_rx_load <= 1'b1;
      else if (rx_done_reg || compat_reg)
         o_rx_load <= 1'b0;
   end

   // Zero seed or compatibility mode bypasses the transmit path.
   always_ff @(posedge i_clk_sys or negedge i_reset_n)
   begin
      if (!i_reset_n)
         o_tx_bypass <= 1'b1;
      else
         o_tx_bypass <= compat_reg || (o_tx_seed == `PESC_SEED_ZERO);
   end

   // Zero seed or compatibility mode bypasses the receive path.
   always_ff @(posedge i_clk_sys or negedge i_reset_n)
   begin
      if (!i_reset_n)
         o_rx_bypass <= 1'b1;
      else
         o_rx_bypass <= compat_reg || (o_rx_seed == `PESC_SEED_ZERO);
   end

   // ************************************************************
   // Interrupt status and mask.
   // ************************************************************
   // Sticky status, its mask and the events of this cycle.
   logic [`PESC_IRQ_W-1:0] irq_status_reg;
   logic [`PESC_IRQ_W-1:0] irq_mask_reg;
   logic [`PESC_IRQ_W-1:0] irq_event;

   // Counted events and range events raise the sticky bits.
   assign irq_event = {rxe_top, fc_top, rxe_end, fc_end};

   // Sticky bits: a new event wins over a write-one clear.
   always_ff @(posedge i_clk_sys or negedge i_reset_n)
   begin
      if (!i_reset_n)
         irq_status_reg <= 4'h0;
      else
         irq_status_reg <= (irq_status_reg & ~(wr_ist ? i_wdata[`PESC_IRQ_W-1:0] : 4'h0))
                           | irq_event;
   end

   // Mask register, same layout as the status bits.
   always_ff @(posedge i_clk_sys or negedge i_reset_n)
   begin
      if (!i_reset_n)
         irq_mask_reg <= 4'h0;
      else if (wr_imask)
         irq_mask_reg <= i_wdata[`PESC_IRQ_W-1:0];
   end

   // Level interrupt, one cycle behind the status and mask.
   always_ff @(posedge i_clk_sys or negedge i_reset_n)
   begin
      if (!i_reset_n)
         o_irq <= 1'b0;
      else
         o_irq <= |(irq_status_reg & irq_mask_reg);
   end

   // ************************************************************
   // Read data, valid in the cycle after the strobe.
   // ************************************************************
   pesc_word_t rdata_next;

   // Reserved seed bits read as zero; unmapped indices read zero.
   always_comb
   begin
      rdata_next = 16'h0000;
      unique case (i_addr)
         `PESC_ADDR_FALSE_CARRIER: rdata_next = fc_count;
         `PESC_ADDR_TX_SEED:       rdata_next = {o_tx_load, 4'h0, o_tx_seed};
         `PESC_ADDR_RX_ERR:        rdata_next = rxe_count;
         `PESC_ADDR_RX_SEED:       rdata_next = {o_rx_load, 4'h0, o_rx_seed};
         `PESC_ADDR_IRQ_STATUS:    rdata_next = {12'h000, irq_status_reg};
         `PESC_ADDR_IRQ_MASK:      rdata_next = {12'h000, irq_mask_reg};
         default:                  rdata_next = 16'h0000;
      endcase
   end

   // Read data stand for one cycle, then fall back to zero.
   always_ff @(posedge i_clk_sys or negedge i_reset_n)
   begin
      if (!i_reset_n)
         o_rdata <= 16'h0000;
      else if (i_rd)
         o_rdata <= rdata_next;
      else
         o_rdata <= 16'h0000;
   end
endmodule
`default_nettype wire

// file: pesc_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Checker on the register port and the seed outputs.
// ************************************************************
module pesc_top_asserts
(
   input wire logic        i_clk_sys,      // System clock.
   input wire logic        i_reset_n,      // Asynchronous reset, active low.
   input wire logic [4:0]  i_addr,         // Register index.
   input wire logic [15:0] i_wdata,        // Write data.
   input wire logic        i_wr,           // Write strobe.
   input wire logic        i_rd,           // Read strobe.
   input wire logic [15:0] o_rdata,        // Read data.
   input wire logic        i_compat_mode,  // Compatibility mode level.
   input wire logic        i_tx_load_done, // Scrambler took the seed.
   input wire logic        i_rx_load_done, // Descrambler took the seed.
   input wire logic [10:0] o_tx_seed,      // Scrambler seed.
   input wire logic        o_tx_load,      // Scrambler load request.
   input wire logic        o_tx_bypass,    // Scrambler bypassed.
   input wire logic [10:0] o_rx_seed,      // Descrambler seed.
   input wire logic        o_rx_load,      // Descrambler load request.
   input wire logic        o_rx_bypass     // Descrambler bypassed.
);
   logic [2:0] quiet_reg;  // Edges seen with compatibility mode low.
   logic [2:0] compat_reg; // Edges seen with compatibility mode high.
   // Saturating run lengths, so the sync lag of the mode input is covered.
   always_ff @(posedge i_clk_sys or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         quiet_reg <= 3'h0;
         compat_reg <= 3'h0;
      end
      else
      begin
         quiet_reg <= i_compat_mode ? 3'h0 : quiet_reg + {2'h0, quiet_reg != 3'h4};
         compat_reg <= !i_compat_mode ? 3'h0 : compat_reg + {2'h0, compat_reg != 3'h4};
      end
   end
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_reset_n);
   a_rdata_idle_zero: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
      else $error("read data not zero outside the answer cycle");
   a_tx_load_set: assert property (i_wr && i_addr == 5'h14 && i_wdata[15]
      && quiet_reg == 3'h4 |=> o_tx_load && o_tx_seed == $past(i_wdata[10:0]))
      else $error("scrambler load not requested with the written seed");
   a_rx_load_set: assert property (i_wr && i_addr == 5'h16 && i_wdata[15]
      && quiet_reg == 3'h4 |=> o_rx_load && o_rx_seed == $past(i_wdata[10:0]))
      else $error("descrambler load not requested with the written seed");
   a_tx_zero_bypass: assert property ($past(o_tx_seed) == 11'h000
      && o_tx_seed == 11'h000 |-> o_tx_bypass) else $error("zero scrambler seed not bypassed");
   a_rx_zero_bypass: assert property ($past(o_rx_seed) == 11'h000
      && o_rx_seed == 11'h000 |-> o_rx_bypass) else $error("zero descrambler seed not bypassed");
   a_compat_disables: assert property (compat_reg == 3'h4
      |-> !o_tx_load && !o_rx_load && o_tx_bypass && o_rx_bypass)
      else $error("compatibility mode left a seed enabled");
   a_tx_load_clears: assert property ($rose(i_tx_load_done) ##1 i_tx_load_done
      |-> ##[1:3] !o_tx_load) else $error("scrambler load bit did not clear");
   a_rx_load_clears: assert property ($rose(i_rx_load_done) ##1 i_rx_load_done
      |-> ##[1:3] !o_rx_load) else $error("descrambler load bit did not clear");
   c_tx_load_done: cover property (o_tx_load ##1 !o_tx_load);
   c_compat_write: cover property (compat_reg == 3'h4 && i_wr);
   c_rx_seed_used: cover property ($fell(o_rx_bypass));
endmodule
bind pesc_top pesc_top_asserts chk (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
   .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
   .i_compat_mode(i_compat_mode), .i_tx_load_done(i_tx_load_done),
   .i_rx_load_done(i_rx_load_done), .o_tx_seed(o_tx_seed), .o_tx_load(o_tx_load),
   .o_tx_bypass(o_tx_bypass), .o_rx_seed(o_rx_seed), .o_rx_load(o_rx_load),
   .o_rx_bypass(o_rx_bypass));
`default_nettype wire

// file: pesc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Register level test of the counters and seed registers.
// ************************************************************
module pesc_top_tb;
   logic        i_clk_sys, i_reset_n, i_wr, i_rd, i_false_carrier, i_rx_err_pkt;
   logic        i_compat_mode, i_tx_load_done, i_rx_load_done;
   logic        o_tx_load, o_tx_bypass, o_rx_load, o_rx_bypass, o_irq;
   logic [4:0]  i_addr;
   logic [15:0] i_wdata, o_rdata;
   logic [10:0] o_tx_seed, o_rx_seed;
   logic [4:0]  seed_addr;
   int          err_count, total_checks;
   pesc_top uut (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_false_carrier(i_false_carrier), .i_rx_err_pkt(i_rx_err_pkt),
      .i_compat_mode(i_compat_mode), .i_tx_load_done(i_tx_load_done),
      .i_rx_load_done(i_rx_load_done), .o_tx_seed(o_tx_seed), .o_tx_load(o_tx_load),
      .o_tx_bypass(o_tx_bypass), .o_rx_seed(o_rx_seed), .o_rx_load(o_rx_load),
      .o_rx_bypass(o_rx_bypass), .o_irq(o_irq));
   // Free running system clock, 100 ns period.
   initial
   begin
      i_clk_sys = 1'b0;
      forever #50 i_clk_sys = ~i_clk_sys;
   end
   // Compares one value and counts the outcome.
   task automatic chk(input logic [15:0] got, input logic [15:0] want);
      total_checks++;
      if (got !== want)
      begin
         $display("wrong value at %0t: got %h expected %h", $time, got, want);
         err_count++;
      end
   endtask
   // One write cycle on the register port.
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge i_clk_sys);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk_sys);
      i_wr <= 1'b0;
   endtask
   // One read cycle; the data are looked at in the answer cycle only.
   task automatic rd(input logic [4:0] a, input logic [15:0] want);
      @(posedge i_clk_sys);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk_sys);
      i_rd <= 1'b0;
      @(negedge i_clk_sys);
      chk(o_rdata, want);
   endtask
   // Holds one event level high for n cycles, then lets it settle.
   task automatic pulse(input logic rx, input int n);
      @(posedge i_clk_sys);
      if (rx) i_rx_err_pkt <= 1'b1;
      else i_false_carrier <= 1'b1;
      repeat (n) @(posedge i_clk_sys);
      i_rx_err_pkt <= 1'b0;
      i_false_carrier <= 1'b0;
      repeat (8) @(posedge i_clk_sys);
   endtask
   // Prints the counts and the verdict, then stops.
   task automatic conclude;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Main sequence of register accesses and events.
   initial
   begin
      {i_reset_n, i_wr, i_rd, i_false_carrier, i_rx_err_pkt} = 5'h00;
      {i_compat_mode, i_tx_load_done, i_rx_load_done, i_addr, i_wdata} = 24'h000000;
      err_count = 0;
      total_checks = 0;
      repeat (12) @(posedge i_clk_sys);
      i_reset_n <= 1'b1;
      repeat (5) @(posedge i_clk_sys);
      chk(16'({o_tx_bypass, o_rx_bypass, o_tx_load, o_rx_load}), 16'hc);
      rd(5'h13, 16'h0000);
      rd(5'h15, 16'h0000);
      wr(5'h1b, 16'h0001);
      pulse(1'b0, 6);
      chk(16'(o_irq), 16'h0001);
      rd(5'h13, 16'h0001);
      rd(5'h13, 16'h0000);
      rd(5'h1a, 16'h0001);
      wr(5'h1a, 16'h0001);
      repeat (3) @(posedge i_clk_sys);
      chk(16'(o_irq), 16'h0000);
      pulse(1'b1, 3);
      pulse(1'b1, 3);
      rd(5'h15, 16'h0002);
      rd(5'h15, 16'h0000);
      // Event end lands in the same cycle as a clearing read.
      @(posedge i_clk_sys);
      i_false_carrier <= 1'b1;
      repeat (3) @(posedge i_clk_sys);
      i_false_carrier <= 1'b0;
      @(posedge i_clk_sys);
      rd(5'h13, 16'h0000);
      rd(5'h13, 16'h0001);
      for (int k = 0; k < 2; k++)
      begin
         seed_addr = 5'(5'h14 + 2 * k);
         wr(seed_addr, 16'(16'h8123 + k));
         repeat (3) @(negedge i_clk_sys);
         chk(16'(k ? o_rx_load : o_tx_load), 16'h0001);
         chk(16'(k ? o_rx_seed : o_tx_seed), 16'(16'h0123 + k));
         chk(16'(k ? o_rx_bypass : o_tx_bypass), 16'h0000);
         @(posedge i_clk_sys);
         i_tx_load_done <= (k == 0);
         i_rx_load_done <= (k == 1);
         repeat (5) @(posedge i_clk_sys);
         {i_tx_load_done, i_rx_load_done} <= 2'h0;
         rd(seed_addr, 16'(16'h0123 + k));
         wr(seed_addr, 16'h0000);
         repeat (3) @(negedge i_clk_sys);
         chk(16'(k ? o_rx_bypass : o_tx_bypass), 16'h0001);
      end
      @(posedge i_clk_sys);
      i_compat_mode <= 1'b1;
      repeat (5) @(posedge i_clk_sys);
      wr(5'h14, 16'h8055);
      wr(5'h16, 16'h8066);
      repeat (3) @(negedge i_clk_sys);
      chk(16'({o_tx_load, o_rx_load, o_tx_bypass, o_rx_bypass}), 16'h0003);
      rd(5'h14, 16'h0000);
      rd(5'h16, 16'h0000);
      @(posedge i_clk_sys);
      i_compat_mode <= 1'b0;
      rd(5'h00, 16'h0000);
      // A reset in mid-run clears the load bit, the seed and the receive-error count.
      wr(5'h14, 16'h8321);
      pulse(1'b1, 2);
      @(negedge i_clk_sys);
      chk(16'({o_tx_load, o_tx_bypass, o_tx_seed}), 16'h1321);
      @(posedge i_clk_sys);
      i_reset_n <= 1'b0;
      @(posedge i_clk_sys);
      i_reset_n <= 1'b1;
      repeat (2) @(negedge i_clk_sys);
      chk(16'({o_tx_load, o_tx_bypass, o_tx_seed}), 16'h0800);
      rd(5'h15, 16'h0000);
      conclude;
   end
   // Cuts a hung run short after far more cycles than the tests need.
   initial
   begin
      repeat (5000) @(posedge i_clk_sys);
      err_count++;
      conclude;
   end
endmodule
`default_nettype wire
